// ---- hw/rtcirq_alarm_store.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtcirq_alarm_store (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [rtcirq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rtcirq_pkg::DATA_W-1:0] wdata_i,
  output logic [rtcirq_pkg::ALARM_SLOTS*8-1:0] bytes_o
);
  import rtcirq_pkg::*;

  logic [7:0] mem_q [ALARM_SLOTS];
  logic [3:0] idx;

  // The second bank is plain storage until enabled by the owner
  assign idx = alarm_index(addr_i);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < ALARM_SLOTS; i++) begin
        mem_q[i] <= BYTE_RST;
      end
    end else if (wr_i && idx != ALARM_NONE) begin
      mem_q[idx] <= wdata_i;
    end
  end

  // Every byte is visible at once so both comparators run in parallel
  for (genvar g = 0; g < ALARM_SLOTS; g++) begin : g_out
    assign bytes_o[8*g +: 8] = mem_q[g];
  end

endmodule : rtcirq_alarm_store
`default_nettype wire

// ---- hw/rtcirq_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtcirq_prescaler (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tick_32k_i,
  output logic [rtcirq_pkg::EN_W-1:0] en_o
);
  import rtcirq_pkg::*;

  logic [14:0] div_q;
  logic [1:0] quarter_q;
  logic [5:0] minute_q;
  logic [EN_W-1:0] en_d;

  function automatic logic low_ones(input logic [14:0] v,
                                    input int unsigned n);
    logic [14:0] m;
    m = 15'((32'd1 << n) - 32'd1);
    return (v & m) == m;
  endfunction : low_ones

  // ****************************************************************
  // Single-domain enables from the oscillator tick
  // ****************************************************************
  assign en_d[EN_8192] = tick_32k_i & low_ones(div_q, DIV_8192);
  assign en_d[EN_4096] = tick_32k_i & low_ones(div_q, DIV_4096);
  assign en_d[EN_64] = tick_32k_i & low_ones(div_q, DIV_64);
  assign en_d[EN_16] = tick_32k_i & low_ones(div_q, DIV_16);
  assign en_d[EN_4] = tick_32k_i & low_ones(div_q, DIV_4);
  assign en_d[EN_1] = tick_32k_i & low_ones(div_q, DIV_1);
  assign en_d[EN_QUARTER] = en_d[EN_1] & (quarter_q == QUARTER_LAST);
  assign en_d[EN_MINUTE] = en_d[EN_1] & (minute_q == MINUTE_LAST);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      div_q <= '0;
      en_o <= '0;
    end else begin
      div_q <= div_q + 15'(tick_32k_i);
      en_o <= en_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      quarter_q <= '0;
      minute_q <= '0;
    end else if (en_d[EN_1]) begin
      quarter_q <= quarter_q + 2'h1;
      minute_q <= en_d[EN_MINUTE] ? 6'h00 : minute_q + 6'h01;
    end
  end

endmodule : rtcirq_prescaler
`default_nettype wire

// ---- hw/rtcirq_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtcirq_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [rtcirq_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [rtcirq_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [rtcirq_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic tick_32k_i,
  input wire logic sec_tick_i,
  input wire logic [rtcirq_pkg::FIELD_W-1:0] time_month_i,
  input wire logic [rtcirq_pkg::FIELD_W-1:0] time_date_i,
  input wire logic [rtcirq_pkg::FIELD_W-1:0] time_hour_i,
  input wire logic [rtcirq_pkg::FIELD_W-1:0] time_min_i,
  input wire logic [rtcirq_pkg::FIELD_W-1:0] time_sec_i,
  input wire logic backup_mode_i,
  input wire logic power_down_i,
  input wire logic battery_weak_i,
  input wire logic osc_stopped_i,
  output logic shared_interrupt_pin_o,
  output logic shared_interrupt_pin_oe_o
);
  import rtcirq_pkg::*;

  // ****************************************************************
  // Pin synchronisers: backup, power-down, battery, oscillator
  // ****************************************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic in_backup;
  logic in_pd;
  logic batt_flag;
  logic osc_flag;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {osc_stopped_i, battery_weak_i, power_down_i, backup_mode_i};
      sync2_q <= sync1_q;
    end
  end

  assign in_backup = sync2_q[0];
  assign in_pd = sync2_q[1];
  assign batt_flag = sync2_q[2];
  assign osc_flag = sync2_q[3];

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic wr_out;
  logic wr_wd;
  logic wr_cnt;
  logic wr_ctrl;
  logic wr_misc;
  logic rd_flags;
  logic ptr_on_flags;
  logic [3:0] aidx;

  assign wr_out = reg_wr_i & (reg_addr_i == ADDR_OUT_CTRL);
  assign wr_wd = reg_wr_i & (reg_addr_i == ADDR_WDOG);
  assign wr_cnt = reg_wr_i & (reg_addr_i == ADDR_CD_VALUE);
  assign wr_ctrl = reg_wr_i & (reg_addr_i == ADDR_CD_CTRL);
  assign wr_misc = reg_wr_i & (reg_addr_i == ADDR_MISC);
  assign rd_flags = reg_rd_i & (reg_addr_i == ADDR_FLAGS);
  assign ptr_on_flags = reg_addr_i == ADDR_FLAGS;
  assign aidx = alarm_index(reg_addr_i);

  // Set wins over a clear in the same cycle
  function automatic logic sticky(input logic q, input logic set,
                                  input logic clr);
    return set | (q & ~clr);
  endfunction : sticky

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic out_level_q;
  logic [7:0] wd_reg_q;
  logic [7:0] ctrl_q;
  logic alarm_irq_enable_q;
  logic abe_q;
  logic osc_fail_irq_enable_q;
  logic second_alarm_enable_q;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      out_level_q <= OUT_LEVEL_RST;
      wd_reg_q <= BYTE_RST;
      alarm_irq_enable_q <= 1'b0;
      abe_q <= 1'b0;
      osc_fail_irq_enable_q <= 1'b0;
      second_alarm_enable_q <= 1'b0;
    end else begin
      if (wr_out) out_level_q <= reg_wdata_i[OUT_LEVEL];
      if (wr_wd) wd_reg_q <= reg_wdata_i;
      if (wr_misc) begin
        alarm_irq_enable_q <= reg_wdata_i[MISC_ALARM_IRQ_ENABLE];
        abe_q <= reg_wdata_i[MISC_ABE];
        osc_fail_irq_enable_q <= reg_wdata_i[MISC_OSC_FAIL_IRQ_ENABLE];
        second_alarm_enable_q <= reg_wdata_i[MISC_SECOND_ALARM_ENABLE];
      end
    end
  end

  // Power-down wins over a write so the timer never runs unpowered
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= BYTE_RST;
    end else if (in_pd) begin
      ctrl_q[CTRL_TE] <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata_i & CTRL_WMASK;
    end
  end

  // ****************************************************************
  // Timebase and alarm storage
  // ****************************************************************
  logic [EN_W-1:0] en;
  logic [ALARM_SLOTS*8-1:0] al_bytes;

  rtcirq_prescaler u_prescaler (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_32k_i(tick_32k_i),
    .en_o(en)
  );

  rtcirq_alarm_store u_alarm_store (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_i(reg_wr_i),
    .addr_i(reg_addr_i),
    .wdata_i(reg_wdata_i),
    .bytes_o(al_bytes)
  );

  // ****************************************************************
  // Alarms
  // ****************************************************************
  logic [34:0] now;
  logic a1_set;
  logic a2_set;
  logic af1_q;
  logic af2_q;

  function automatic logic alarm_match(input logic [39:0] al,
                                       input logic [34:0] t);
    logic [4:0] eq;
    logic [4:0] rpt;
    rpt = {al[7], al[15], al[23], al[31], al[39]};
    eq = {al[6:0] == t[34:28], al[14:8] == t[27:21],
          al[22:16] == t[20:14], al[30:24] == t[13:7],
          al[38:32] == t[6:0]};
    return &(eq | ~rpt_mask(rpt));
  endfunction : alarm_match

  assign now = {time_month_i, time_date_i, time_hour_i, time_min_i,
                time_sec_i};
  // A parked pointer drops the match rather than deferring it
  assign a1_set = sec_tick_i & ~ptr_on_flags
                  & alarm_match(al_bytes[39:0], now);
  assign a2_set = sec_tick_i & ~ptr_on_flags & second_alarm_enable_q
                  & alarm_match(al_bytes[79:40], now);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      af1_q <= 1'b0;
      af2_q <= 1'b0;
    end else begin
      af1_q <= sticky(af1_q, a1_set, rd_flags);
      af2_q <= sticky(af2_q, a2_set, rd_flags);
    end
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  rtcirq_wd_state_type wd_state_q;
  rtcirq_wd_state_type wd_state_d;
  logic [4:0] wd_cnt_q;
  logic [4:0] wd_mult;
  logic [3:0] wd_res_en;
  logic wd_tick;
  logic wd_hit;
  logic wdf_q;

  assign wd_mult = wd_reg_q[6:2];
  assign wd_res_en = {en[EN_QUARTER], en[EN_1], en[EN_4], en[EN_16]};
  assign wd_tick = wd_res_en[wd_reg_q[1:0]];
  // A restart in the timeout cycle wins, so flag and state are set in the same cycle
  assign wd_hit = (wd_state_q == WD_RUN) & wd_tick & ~wr_wd
                  & (5'(wd_cnt_q + 5'h01) == wd_mult);

  always_comb begin
    wd_state_d = wd_state_q;
    unique case (wd_state_q)
      WD_OFF, WD_RUN: begin
        if (wr_wd) begin
          wd_state_d = (reg_wdata_i[6:2] != 5'h00) ? WD_RUN : WD_OFF;
        end else if (wd_hit) begin
          wd_state_d = WD_EXPIRED;
        end
      end
      WD_EXPIRED: begin
        if (wr_wd && reg_wdata_i == WD_RELEASE) wd_state_d = WD_OFF;
      end
      default: wd_state_d = WD_OFF;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wd_state_q <= WD_OFF;
      wd_cnt_q <= 5'h00;
      wdf_q <= 1'b0;
    end else begin
      wd_state_q <= wd_state_d;
      if (wr_wd) wd_cnt_q <= 5'h00;
      else if (wd_state_q == WD_RUN && wd_tick) wd_cnt_q <= wd_cnt_q + 5'h01;
      wdf_q <= sticky(wdf_q, wd_hit, rd_flags);
    end
  end

  // ****************************************************************
  // Countdown timer
  // ****************************************************************
  logic [7:0] count_q;
  logic [7:0] load_q;
  logic [7:0] pulse_q;
  logic [7:0] pulse_len;
  logic [3:0] src_en;
  logic cd_tick;
  logic cd_run;
  logic cd_expire;
  logic pulse_on;
  logic tf_q;

  assign src_en = {en[EN_MINUTE], en[EN_1], en[EN_64], en[EN_4096]};
  assign cd_tick = src_en[ctrl_q[1:0]];
  assign cd_run = ctrl_q[CTRL_TE] & (load_q != 8'h00);
  assign cd_expire = cd_run & cd_tick & (count_q <= 8'h01);
  assign pulse_on = ctrl_q[CTRL_TE] & ctrl_q[CTRL_TIE] & ctrl_q[CTRL_TP];
  assign pulse_len = (ctrl_q[1:0] == 2'h0) ?
                       ((load_q == 8'h01) ? PULSE_FAST_ONE : PULSE_FAST) :
                     (ctrl_q[1:0] == 2'h1) ?
                       ((load_q == 8'h01) ? PULSE_MID_ONE : PULSE_SLOW) :
                     PULSE_SLOW;

  // The held count survives a stop so counting resumes where it left off
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      count_q <= BYTE_RST;
      load_q <= BYTE_RST;
    end else if (wr_cnt) begin
      count_q <= reg_wdata_i;
      load_q <= reg_wdata_i;
    end else if (cd_expire) begin
      count_q <= load_q;
    end else if (cd_run && cd_tick) begin
      count_q <= count_q - 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tf_q <= 1'b0;
      pulse_q <= 8'h00;
    end else begin
      tf_q <= sticky(tf_q, cd_expire, rd_flags);
      if (!pulse_on) pulse_q <= 8'h00;
      else if (cd_expire) pulse_q <= pulse_len;
      else if (pulse_q != 8'h00 && en[EN_8192]) pulse_q <= pulse_q - 8'h01;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] flags_rd;
  logic [7:0] misc_rd;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  assign flags_rd = {wdf_q, af1_q, af2_q, batt_flag, tf_q, osc_flag, 2'b00};
  assign misc_rd = {alarm_irq_enable_q, abe_q, osc_fail_irq_enable_q, 3'b000, second_alarm_enable_q, 1'b0};
  assign rd_mux = (aidx != ALARM_NONE) ? al_bytes[{aidx, 3'b000} +: 8] :
                  (reg_addr_i == ADDR_OUT_CTRL) ? {out_level_q, 7'h00} :
                  (reg_addr_i == ADDR_WDOG) ? wd_reg_q :
                  (reg_addr_i == ADDR_FLAGS) ? flags_rd :
                  (reg_addr_i == ADDR_CD_VALUE) ? count_q :
                  (reg_addr_i == ADDR_CD_CTRL) ? ctrl_q :
                  (reg_addr_i == ADDR_MISC) ? misc_rd : 8'h00;

  // Flags are captured before the clear lands, hence the later read
  always_ff @(posedge clk_i) begin
    if (!nrst_i) rdata_q <= 8'h00;
    else if (reg_rd_i) rdata_q <= rd_mux;
  end

  assign reg_rdata_o = rdata_q;

  // ****************************************************************
  // Shared interrupt pin
  // ****************************************************************
  logic alarm_irq;
  logic wd_irq;
  logic timer_irq;
  logic osc_irq;
  logic any_en;
  logic pin_src;
  logic pin_oe_q;
  logic pin_q;

  assign alarm_irq = alarm_irq_enable_q & (af1_q | af2_q) & (~in_backup | abe_q);
  assign wd_irq = wd_state_q == WD_EXPIRED;
  assign timer_irq = ctrl_q[CTRL_TIE] & (ctrl_q[CTRL_TP] ?
                     (pulse_on & (pulse_q != 8'h00)) : tf_q);
  assign osc_irq = osc_fail_irq_enable_q & osc_flag;
  assign any_en = alarm_irq_enable_q | osc_fail_irq_enable_q | ctrl_q[CTRL_TIE] | (wd_state_q != WD_OFF);
  assign pin_src = alarm_irq | wd_irq | timer_irq | osc_irq;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pin_oe_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      pin_oe_q <= pin_src | (~any_en & ~out_level_q);
      pin_q <= 1'b0;
    end
  end

  assign shared_interrupt_pin_oe_o = pin_oe_q;
  assign shared_interrupt_pin_o = pin_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_alarm_parked: assert property (
    sec_tick_i && ptr_on_flags && !af1_q |=> !af1_q)
    else $error("alarm flag set while pointer parked");
  a_flag_read: assert property (
    rd_flags && !a1_set && af1_q |=> !af1_q && reg_rdata_o[FLAG_AF1])
    else $error("flags read did not clear alarm flag");
  a_wd_timeout: assert property (
    wd_hit |=> wdf_q && wd_state_q == WD_EXPIRED ##1 pin_oe_q)
    else $error("watchdog timeout not flagged");
  a_wd_restart: assert property (
    wr_wd && reg_wdata_i[6:2] != 5'h00 && wd_state_q != WD_EXPIRED
    |=> wd_cnt_q == 5'h00 && wd_state_q == WD_RUN)
    else $error("watchdog write did not restart");
  a_wd_release: assert property (
    wd_state_q == WD_EXPIRED && wr_wd && reg_wdata_i == WD_RELEASE
    |=> wd_state_q == WD_OFF)
    else $error("watchdog not released by zero write");
  a_timer_reload: assert property (
    cd_expire && !wr_cnt |=> count_q == $past(load_q) && tf_q)
    else $error("timer did not reload at expiry");
  a_tf_sticky: assert property (
    tf_q && !rd_flags |=> tf_q)
    else $error("timer flag cleared without a read");
  a_level_irq: assert property (
    !ctrl_q[CTRL_TP] && ctrl_q[CTRL_TIE] && tf_q |=> pin_oe_q)
    else $error("level mode interrupt missing");
  a_pulse_stop: assert property (
    $fell(pulse_on) |=> pulse_q == 8'h00)
    else $error("pulses continue after disable");
  a_power_down: assert property (
    in_pd |=> !ctrl_q[CTRL_TE])
    else $error("run enable survives power-down");
  a_idle_level: assert property (
    !any_en && !pin_src |=> pin_oe_q == !$past(out_level_q))
    else $error("idle pin does not follow level bit");
  a_open_drain: assert property (
    shared_interrupt_pin_o == 1'b0)
    else $error("pin driven high");

  c_timer_expire: cover property (cd_expire && pulse_on);
  c_wd_expire: cover property (wd_hit);
  c_alarm_two: cover property (a2_set ##1 rd_flags);
  c_pulse_end: cover property ((pulse_q == 8'h01) && en[EN_8192]);

endmodule : rtcirq_top
`default_nettype wire

// ---- include/rtcirq_pkg.sv ----
`default_nettype none
package rtcirq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIELD_W = 7;
  localparam logic [4:0] ADDR_OUT_CTRL = 5'h08;
  localparam logic [4:0] ADDR_WDOG = 5'h09;
  localparam logic [4:0] ADDR_ALARM1 = 5'h0A;
  localparam logic [4:0] ADDR_ALARM1_END = 5'h0E;
  localparam logic [4:0] ADDR_FLAGS = 5'h0F;
  localparam logic [4:0] ADDR_CD_VALUE = 5'h10;
  localparam logic [4:0] ADDR_CD_CTRL = 5'h11;
  localparam logic [4:0] ADDR_MISC = 5'h13;
  localparam logic [4:0] ADDR_ALARM2 = 5'h14;
  localparam logic [4:0] ADDR_ALARM2_END = 5'h18;
  localparam logic [3:0] ALARM_BYTES = 4'h5;
  localparam int unsigned ALARM_SLOTS = 10;
  localparam logic [3:0] ALARM_NONE = 4'hF;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned OUT_LEVEL = 7;
  localparam int unsigned FLAG_AF1 = 6;
  localparam int unsigned CTRL_TE = 7;
  localparam int unsigned CTRL_TP = 6;
  localparam int unsigned CTRL_TIE = 5;
  localparam logic [7:0] CTRL_WMASK = 8'hE3;
  localparam int unsigned MISC_ALARM_IRQ_ENABLE = 7;
  localparam int unsigned MISC_ABE = 6;
  localparam int unsigned MISC_OSC_FAIL_IRQ_ENABLE = 5;
  localparam int unsigned MISC_SECOND_ALARM_ENABLE = 1;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic OUT_LEVEL_RST = 1'b1;
  localparam logic [7:0] WD_RELEASE = 8'h00;

  // ****************************************************************
  // Timebase: bits of the 32.768 kHz divider per enable
  // ****************************************************************
  localparam int unsigned EN_W = 8;
  localparam int unsigned EN_8192 = 0;
  localparam int unsigned EN_4096 = 1;
  localparam int unsigned EN_64 = 2;
  localparam int unsigned EN_16 = 3;
  localparam int unsigned EN_4 = 4;
  localparam int unsigned EN_1 = 5;
  localparam int unsigned EN_QUARTER = 6;
  localparam int unsigned EN_MINUTE = 7;
  localparam int unsigned DIV_8192 = 2;
  localparam int unsigned DIV_4096 = 3;
  localparam int unsigned DIV_64 = 9;
  localparam int unsigned DIV_16 = 11;
  localparam int unsigned DIV_4 = 13;
  localparam int unsigned DIV_1 = 15;
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [5:0] MINUTE_LAST = 6'h3B;

  // Pulse lengths counted in 8192 Hz ticks
  localparam logic [7:0] PULSE_FAST_ONE = 8'h01;
  localparam logic [7:0] PULSE_FAST = 8'h02;
  localparam logic [7:0] PULSE_MID_ONE = 8'h40;
  localparam logic [7:0] PULSE_SLOW = 8'h80;

  typedef enum logic [2:0] {
    WD_OFF = 3'b001,
    WD_RUN = 3'b010,
    WD_EXPIRED = 3'b100
  } rtcirq_wd_state_type;

  // Slot 0..4 for the first alarm, 5..9 for the second
  function automatic logic [3:0] alarm_index(input logic [4:0] a);
    logic [3:0] idx;
    idx = ALARM_NONE;
    if (a >= ADDR_ALARM1 && a <= ADDR_ALARM1_END) begin
      idx = 4'(a - ADDR_ALARM1);
    end else if (a >= ADDR_ALARM2 && a <= ADDR_ALARM2_END) begin
      idx = 4'(a - ADDR_ALARM2) + ALARM_BYTES;
    end
    return idx;
  endfunction : alarm_index

  // Compare mask {month, date, hour, minute, second}
  function automatic logic [4:0] rpt_mask(input logic [4:0] rpt);
    logic [4:0] m;
    case (rpt)
      5'h1F: m = 5'h00;
      5'h1E: m = 5'h01;
      5'h1C: m = 5'h03;
      5'h18: m = 5'h07;
      5'h10: m = 5'h0F;
      5'h00: m = 5'h1F;
      default: m = 5'h00;
    endcase
    return m;
  endfunction : rpt_mask

endpackage : rtcirq_pkg
`default_nettype wire

// ---- sim/rtc_alarm_watchdog_timer_irq_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtc_alarm_watchdog_timer_irq_bench;
  import rtcirq_pkg::*;
  // ****************************************************************
  // Stimulus, expectation queue and checks
  // ****************************************************************
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic sec_tick = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] lfsr = 8'h05;
  logic [4:0] addr;
  logic reg_wr, rd, oe, pin_o;
  logic backup_on = 1'b0;
  logic pwr_down = 1'b0;
  logic [7:0] wdata, rdata;
  logic [7:0] exp_q[$];
  logic [4:0] ra[7] = '{5'h08, 5'h09, 5'h0F, 5'h10, 5'h11, 5'h13, 5'h1F};
  logic [7:0] rv[7] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Board pull-up: the pin only ever pulls low
  wire pin = oe ? 1'b0 : 1'b1;
  rtcirq_host_model u_host (.clk_i(clk_i), .addr_o(addr), .wr_o(reg_wr),
    .rd_o(rd), .wdata_o(wdata));
  rtcirq_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
    .reg_wr_i(reg_wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata),
    .tick_32k_i(1'b1), .sec_tick_i(sec_tick), .time_month_i(lfsr[6:0]),
    .time_date_i(lfsr[7:1]), .time_hour_i(~lfsr[6:0]),
    .time_min_i(lfsr[6:0]), .time_sec_i(~lfsr[7:1]),
    .backup_mode_i(backup_on), .power_down_i(pwr_down),
    .battery_weak_i(1'b0),
    .osc_stopped_i(1'b0), .shared_interrupt_pin_o(pin_o),
    .shared_interrupt_pin_oe_o(oe));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Waits up to n cycles for the wire level, then compares it
  task automatic chk_pin(input logic e, input int n);
    for (int i = 0; i < n && pin !== e; i++) @(negedge clk_i);
    chk({7'h00, pin}, {7'h00, e});
  endtask : chk_pin
  task automatic rd_exp(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(a, 8'h00, 1'b0);
  endtask : rd_exp
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.xfer(a, d, 1'b1);
  endtask : wr
  task automatic sec();
    @(negedge clk_i);
    sec_tick <= 1'b1;
    @(negedge clk_i);
    sec_tick <= 1'b0;
  endtask : sec
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) rd_seen <= rd;
  always @(negedge clk_i) begin
    lfsr <= lfsr_next(lfsr);
    cyc++;
    if (rd_seen) chk(rdata, exp_q.pop_front());
    if (cyc > 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(negedge clk_i);
    nrst_i <= 1'b1;
    foreach (ra[i]) rd_exp(ra[i], rv[i]);
    chk_pin(1'b1, 0);
    wr(ADDR_OUT_CTRL, 8'h00);
    chk_pin(1'b0, 4);
    wr(ADDR_OUT_CTRL, 8'h80);
    chk_pin(1'b1, 4);
    wr(5'h1F, 8'hFF);
    rd_exp(5'h1F, 8'h00);
    wr(ADDR_CD_CTRL, 8'hFF);
    rd_exp(ADDR_CD_CTRL, 8'hE3);
    repeat (40) @(negedge clk_i);
    chk_pin(1'b1, 0);
    wr(ADDR_CD_CTRL, 8'h00);
    // Two units of 1/16 s, so an early first enable cannot fire it
    wr(ADDR_WDOG, 8'h08);
    repeat (1500) @(negedge clk_i);
    wr(ADDR_WDOG, 8'h08);
    repeat (1500) @(negedge clk_i);
    chk_pin(1'b1, 0);
    chk_pin(1'b0, 3000);
    rd_exp(ADDR_FLAGS, 8'h80);
    rd_exp(ADDR_FLAGS, 8'h00);
    chk_pin(1'b0, 0);
    wr(ADDR_WDOG, 8'h00);
    chk_pin(1'b1, 4);
    wr(ADDR_CD_VALUE, 8'h02);
    wr(ADDR_CD_CTRL, 8'hA0);
    chk_pin(1'b0, 100);
    pwr_down <= 1'b1;
    repeat (4) @(negedge clk_i);
    rd_exp(ADDR_CD_CTRL, 8'h20);
    pwr_down <= 1'b0;
    repeat (3) @(negedge clk_i);
    wr(ADDR_CD_CTRL, 8'hE0);
    rd_exp(ADDR_FLAGS, 8'h08);
    chk_pin(1'b1, 20);
    chk_pin(1'b0, 40);
    chk_pin(1'b1, 12);
    wr(ADDR_CD_CTRL, 8'h00);
    chk_pin(1'b1, 4);
    rd_exp(ADDR_FLAGS, 8'h08);
    rd_exp(ADDR_FLAGS, 8'h00);
    for (int i = 0; i < 5; i++) wr(ADDR_ALARM1 + 5'(i), 8'h80);
    wr(ADDR_MISC, 8'h80);
    rd_exp(ADDR_MISC, 8'h80);
    sec();
    chk_pin(1'b0, 6);
    rd_exp(ADDR_FLAGS, 8'h40);
    chk_pin(1'b1, 4);
    sec();
    repeat (6) @(negedge clk_i);
    chk_pin(1'b1, 0);
    rd_exp(ADDR_FLAGS, 8'h00);
    wr(ADDR_ALARM1, 8'h00);
    rd_exp(ADDR_OUT_CTRL, 8'h80);
    sec();
    chk_pin(1'b0, 6);
    for (int i = 0; i < 5; i++) wr(ADDR_ALARM1 + 5'(i), 8'h00);
    rd_exp(ADDR_FLAGS, 8'h40);
    for (int i = 0; i < 5; i++) wr(ADDR_ALARM2 + 5'(i), 8'h80);
    sec();
    repeat (6) @(negedge clk_i);
    chk_pin(1'b1, 0);
    rd_exp(ADDR_FLAGS, 8'h00);
    backup_on <= 1'b1;
    wr(ADDR_MISC, 8'h82);
    sec();
    repeat (6) @(negedge clk_i);
    chk_pin(1'b1, 0);
    wr(ADDR_MISC, 8'hC2);
    chk_pin(1'b0, 6);
    rd_exp(ADDR_FLAGS, 8'h20);
    wrap_up();
  end
endmodule : rtc_alarm_watchdog_timer_irq_bench
`default_nettype wire

// ---- sim/rtcirq_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtcirq_host_model (
  input wire logic clk_i,
  output logic [4:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  // ****************************************************************
  // Host register access
  // ****************************************************************
  // The pointer is left where the last access put it, as a real host
  // does, so a flags read parks it on the flags address
  task automatic xfer(input logic [4:0] a, input logic [7:0] d,
                      input logic w);
    @(negedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(negedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    wdata_o <= ~d;
  endtask : xfer
  initial begin
    addr_o = 5'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
endmodule : rtcirq_host_model
`default_nettype wire
